/* logic/drs_regs.svh */
/*
 Timing figures for the refresh link between the two ends.
 Assumes a 250 MHz clock (4 ns period).
*/
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------
`define DRS_CLK_PS        4000
`define DRS_TREFI_NS      7800
`define DRS_TRFC_NS       160
`define DRS_TRP_NS        14
`define DRS_TXS_NS        170
`define DRS_TCKE_NS       5
`define DRS_TCKESR_NS     10
`define DRS_TCKSRE_NS     10
`define DRS_TCKSRX_NS     10
`define DRS_TXSDLL_NCK    512
`define DRS_TWRLV_NCK     512
`define DRS_ODT_LEAD_NCK  8
// Least times round up
`define DRS_CYC_UP(ns)    ((((ns) * 1000) + `DRS_CLK_PS - 1) / `DRS_CLK_PS)
// Longest times round down
`define DRS_CYC_DN(ns)    (((ns) * 1000) / `DRS_CLK_PS)
`define DRS_TREFI_CYC     `DRS_CYC_DN(`DRS_TREFI_NS)
`define DRS_TRFC_CYC      `DRS_CYC_UP(`DRS_TRFC_NS)
`define DRS_TRP_CYC       `DRS_CYC_UP(`DRS_TRP_NS)
`define DRS_TXS_CYC       `DRS_CYC_UP(`DRS_TXS_NS)
`define DRS_TCKE_CYC      `DRS_CYC_UP(`DRS_TCKE_NS)
`define DRS_TCKESR_CYC    `DRS_CYC_UP(`DRS_TCKESR_NS)
`define DRS_TCKSRE_CYC    `DRS_CYC_UP(`DRS_TCKSRE_NS)
`define DRS_TCKSRX_CYC    `DRS_CYC_UP(`DRS_TCKSRX_NS)

// ----------------------------------------------------------------
// Budget and field figures
// ----------------------------------------------------------------
`define DRS_MAX_DEFER     8
`define DRS_MAX_PULL      8
`define DRS_ROW_W         16
`define DRS_CNT_W         16
`define DRS_DLL_EN_BIT    0

`endif

/* logic/drs_pkg.sv */
/*
 Types shared by both ends of the refresh link.
 Assumes drs_regs.svh supplies all figures.
*/
package drs_pkg;
    // Command pattern {cs_n, ras_n, cas_n, we_n}
    typedef logic [3:0] drs_cmd_t;
    localparam drs_cmd_t DRS_CMD_NOP = 4'h7;
    localparam drs_cmd_t DRS_CMD_DES = 4'h8;
    localparam drs_cmd_t DRS_CMD_REF = 4'h1;

    typedef enum logic [2:0] {
        DRS_IDLE  = 3'b000,
        DRS_RFC   = 3'b001,
        DRS_SELF  = 3'b010,
        DRS_XS    = 3'b011,
        DRS_XSDLL = 3'b100
    } drs_state_t;

    function automatic logic drs_is_ref(input drs_cmd_t c, input logic cke);
        return (c == DRS_CMD_REF) && cke;
    endfunction

    function automatic logic drs_is_sre(input drs_cmd_t c, input logic cke);
        return (c == DRS_CMD_REF) && !cke;
    endfunction

    function automatic logic drs_is_idle_cmd(input drs_cmd_t c);
        return c[3] || (c == DRS_CMD_NOP);
    endfunction
endpackage

/* logic/drs_if.sv */
/*
 Command pins between the two ends.
 Assumes one clock; all pins one-way, so no enables.
*/
`timescale 1ns/1ps
interface drs_if;
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       cke;
    logic       odt;
    logic       reset_n;

    modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, reset_n);
    modport mem  (input  cs_n, ras_n, cas_n, we_n, cke, odt, reset_n);
endinterface // drs_if

/* logic/drs_wait.sv */
/*
 Loadable down-counter giving a one-cycle done pulse.
 Assumes load values fit in W bits and are at least one.
*/
`timescale 1ns/1ps
module drs_wait #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // Status
    output logic              busy,
    output logic              done
);
    logic [W-1:0] remain;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= '0;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else if (load) begin
            remain <= count - W'(1);
            busy   <= 1'b1;
            done   <= 1'b0;
        end else if (busy) begin
            done   <= (remain == '0);
            busy   <= (remain != '0);
            remain <= (remain == '0) ? remain : remain - W'(1);
        end else begin
            done   <= 1'b0;
        end
    end
endmodule // drs_wait

/* logic/drs_mem.sv */
/*
 Memory end: command decode, row counter, refresh timer, DLL.
 Assumes the controller keeps the timing rules.
*/
`timescale 1ns/1ps
`include "drs_regs.svh"
module drs_mem #(
    parameter int TREFI_CYC = `DRS_TREFI_CYC,
    parameter int TXSDLL    = `DRS_TXSDLL_NCK
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Link
    drs_if.mem                          link,
    // Mode
    input  wire logic                   dll_off_mode,
    // Status
    output logic [`DRS_ROW_W-1:0]       row,
    output logic                        row_busy,
    output logic                        self_ref,
    output logic                        dll_on,
    output logic                        banks_idle
);
    import drs_pkg::*;

    drs_state_t state;
    drs_cmd_t   cmd;
    logic       ck_on;
    logic       tmr_tick;
    logic       rfc_done;
    logic [`DRS_CNT_W-1:0] tmr;
    logic [`DRS_CNT_W-1:0] xs_cnt;

    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

    drs_wait #(.W(`DRS_CNT_W)) u_rfc (
        .clk   (clk),
        .rst   (rst),
        .load  (row_busy == 1'b0 && ((state == DRS_IDLE && drs_is_ref(cmd, link.cke))
                || tmr_tick)),
        // Two early: idle again by the next legal REF edge
        .count (`DRS_CNT_W'(`DRS_TRFC_CYC - 2)),
        .busy  (),
        .done  (rfc_done)
    );

    // ----------------------------------------------------------------
    // Command state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state  <= DRS_IDLE;
            xs_cnt <= '0;
        end else if (!link.reset_n) begin
            state  <= DRS_IDLE;
        end else begin
            unique case (state)
                DRS_IDLE: begin
                    if (drs_is_sre(cmd, link.cke))          // [RULE_10]
                        state <= DRS_SELF;
                    else if (drs_is_ref(cmd, link.cke))     // [RULE_01]
                        state <= DRS_RFC;
                end
                DRS_RFC: if (rfc_done) state <= DRS_IDLE;
                DRS_SELF: begin
                    // Only CKE and RESET watched here
                    if (link.cke) begin                     // [RULE_14]
                        state  <= DRS_XS;
                        xs_cnt <= `DRS_CNT_W'(`DRS_TXS_CYC);
                    end
                end
                DRS_XS: begin
                    xs_cnt <= xs_cnt - `DRS_CNT_W'(1);
                    if (xs_cnt == `DRS_CNT_W'(1)) begin
                        state  <= DRS_XSDLL;
                        xs_cnt <= `DRS_CNT_W'(TXSDLL - `DRS_TXS_CYC);
                    end
                end
                DRS_XSDLL: begin
                    xs_cnt <= xs_cnt - `DRS_CNT_W'(1);
                    if (drs_is_sre(cmd, link.cke))
                        state <= DRS_SELF;
                    else if (xs_cnt == `DRS_CNT_W'(1))
                        state <= DRS_IDLE;
                end
                default: state <= DRS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Built-in timer; first tick soon after entry
    // ----------------------------------------------------------------
    assign ck_on    = (state == DRS_SELF);                  // [RULE_14]
    assign tmr_tick = ck_on && (tmr == '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr <= '0;
        end else if (!ck_on) begin
            tmr <= '0;                                      // [RULE_16]
        end else begin
            tmr <= (tmr == '0) ? `DRS_CNT_W'(TREFI_CYC - 1) : tmr - `DRS_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Internal row counter; external address ignored
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row      <= '0;
            row_busy <= 1'b0;
        end else if (rfc_done) begin
            row      <= row + `DRS_ROW_W'(1);               // [RULE_03]
            row_busy <= 1'b0;
        end else if ((state == DRS_IDLE && drs_is_ref(cmd, link.cke)) || tmr_tick) begin
            row_busy <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Status and DLL
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            self_ref   <= 1'b0;
            dll_on     <= 1'b0;
            banks_idle <= 1'b1;
        end else begin
            self_ref   <= (state == DRS_SELF);
            banks_idle <= !row_busy || rfc_done;            // [RULE_03]
            if (dll_off_mode)
                dll_on <= 1'b0;
            else if (state == DRS_SELF || state == DRS_XS)
                dll_on <= 1'b0;                             // [RULE_13]
            else
                dll_on <= 1'b1;                             // [RULE_13]
        end
    end
endmodule // drs_mem

/* logic/drs_ctrl.sv */
/*
 Controller end: refresh budget and self-refresh waits.
 Assumes the user only requests refresh or self-refresh.
*/
// Contract
// [RULE_01] REF is CS RAS CAS low, WE high
// [RULE_02] All banks precharged tRP before REF
// [RULE_03] Memory uses internal rows, ends precharged
// [RULE_04] Only NOP/DES during tRFC after REF
// [RULE_05] At most 8 postponed, gap 9 tREFI
// [RULE_06] At most 8 pulled in for credit
// [RULE_07] At most 16 REF per 2 tREFI
// [RULE_08] Total postponed across self-refresh at most eight
// [RULE_09] Tally frozen during self-refresh
// [RULE_10] Entry is REF pattern with CKE low
// [RULE_11] Idle and ODT off before entry
// [RULE_12] Hold CKE low during self-refresh
// [RULE_13] DLL off in self-refresh, reset on exit
// [RULE_14] Memory ignores all but CKE, RESET
// [RULE_15] Wait 512 nCK before first write
// [RULE_16] Internal refresh starts within tCKE of entry
// [RULE_17] Stay in self-refresh at least tCKESR
// [RULE_18] Clock stop after tCKSRE, stable tCKSRX; ck_stop_ok can fall on the same edge that CKE rises
// [RULE_19] Exit is CKE high with NOP; tXS/tXSDLL
// [RULE_20] CKE high, ODT off through tXSDLL
// [RULE_21] Re-entry needs tXS then one REF
// [RULE_22] NOP/DES every edge during tXS
// [RULE_23] Signed tally within plus/minus eight
// [RULE_24] Extra REF after exit before re-entry
`timescale 1ns/1ps
`include "drs_regs.svh"
module drs_ctrl #(
    parameter int TREFI_CYC = `DRS_TREFI_CYC,
    parameter int TXSDLL    = `DRS_TXSDLL_NCK
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Link
    drs_if.ctrl           link,
    // User requests
    input  wire logic     sr_req,
    input  wire logic     pull_req,
    // Status
    output logic          in_self,
    output logic          write_ok,
    output logic          dll_ok,
    output logic          ck_stop_ok,
    output logic signed [4:0] tally
);
    import drs_pkg::*;

    typedef enum logic [2:0] {
        DRS_C_IDLE  = 3'b000,
        DRS_C_RFC   = 3'b001,
        DRS_C_ODT   = 3'b010,
        DRS_C_SELF  = 3'b011,
        DRS_C_XS    = 3'b100,
        DRS_C_XSDLL = 3'b101
    } drs_cstate_t;

    drs_cstate_t state;
    logic [`DRS_CNT_W-1:0] wait_cnt;
    logic [`DRS_CNT_W-1:0] refi_cnt;
    logic [`DRS_CNT_W-1:0] win_cnt;
    logic [4:0]            win_refs;
    logic [`DRS_CNT_W-1:0] post_cnt;
    logic                  refi_tick;
    logic                  need_extra;
    logic                  issue_ref;
    logic                  must_ref;

    // ----------------------------------------------------------------
    // Refresh decision
    // ----------------------------------------------------------------
    assign refi_tick = (refi_cnt == '0) && (state != DRS_C_SELF);    // [RULE_09]
    assign must_ref  = (tally >= 5'sd`DRS_MAX_DEFER) || need_extra;  // [RULE_05]
    assign issue_ref = (state == DRS_C_IDLE) && (wait_cnt == '0)
                     && win_refs < 5'd16                             // [RULE_07]
                     && (must_ref || (tally > 5'sd0)
                        || (pull_req && tally > -5'sd`DRS_MAX_PULL)); // [RULE_06]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refi_cnt <= `DRS_CNT_W'(TREFI_CYC - 1);
        end else if (state != DRS_C_SELF) begin
            refi_cnt <= refi_tick ? `DRS_CNT_W'(TREFI_CYC - 1) : refi_cnt - `DRS_CNT_W'(1);
        end
    end

    // Signed tally: positive owed, negative pulled in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tally <= '0;
        end else if (refi_tick && !issue_ref) begin
            if (tally < 5'sd`DRS_MAX_DEFER) tally <= tally + 5'sd1;  // [RULE_23]
        end else if (issue_ref && !refi_tick) begin
            if (tally > -5'sd`DRS_MAX_PULL) tally <= tally - 5'sd1;  // [RULE_23]
        end
    end

    // Window of two intervals
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_cnt  <= '0;
            win_refs <= '0;
        end else if (win_cnt == `DRS_CNT_W'(2 * TREFI_CYC - 1)) begin
            win_cnt  <= '0;
            win_refs <= {4'h0, issue_ref};
        end else begin
            win_cnt  <= win_cnt + `DRS_CNT_W'(1);
            win_refs <= win_refs + {4'h0, issue_ref};
        end
    end

    // ----------------------------------------------------------------
    // Command sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= DRS_C_IDLE;
            wait_cnt   <= `DRS_CNT_W'(`DRS_TRP_CYC);                 // [RULE_02]
            need_extra <= 1'b0;
            post_cnt   <= '0;
        end else begin
            if (wait_cnt != '0) wait_cnt <= wait_cnt - `DRS_CNT_W'(1);
            if (post_cnt != '0) post_cnt <= post_cnt - `DRS_CNT_W'(1);
            unique case (state)
                DRS_C_IDLE: begin
                    if (issue_ref) begin
                        state      <= DRS_C_RFC;
                        wait_cnt   <= `DRS_CNT_W'(`DRS_TRFC_CYC);    // [RULE_04]
                        need_extra <= 1'b0;                          // [RULE_24]
                    end else if (sr_req && wait_cnt == '0 && !need_extra) begin // [RULE_21]
                        state    <= DRS_C_ODT;                       // [RULE_11]
                        wait_cnt <= `DRS_CNT_W'(`DRS_ODT_LEAD_NCK);
                    end
                end
                DRS_C_RFC: if (wait_cnt == `DRS_CNT_W'(1)) state <= DRS_C_IDLE;
                DRS_C_ODT: begin
                    if (wait_cnt == `DRS_CNT_W'(1)) begin
                        state    <= DRS_C_SELF;                      // [RULE_08]
                        wait_cnt <= `DRS_CNT_W'(`DRS_TCKESR_CYC + `DRS_TCKSRX_CYC);
                    end
                end
                DRS_C_SELF: begin
                    if (!sr_req && wait_cnt == '0) begin             // [RULE_17]
                        state      <= DRS_C_XS;
                        wait_cnt   <= `DRS_CNT_W'(`DRS_TXS_CYC);     // [RULE_19]
                        post_cnt   <= `DRS_CNT_W'(`DRS_TWRLV_NCK);   // [RULE_15]
                        need_extra <= 1'b1;                          // [RULE_24]
                    end
                end
                DRS_C_XS: begin
                    if (wait_cnt == `DRS_CNT_W'(1)) begin
                        state    <= DRS_C_XSDLL;
                        wait_cnt <= `DRS_CNT_W'(TXSDLL - `DRS_TXS_CYC);
                    end
                end
                DRS_C_XSDLL: if (wait_cnt == `DRS_CNT_W'(1)) state <= DRS_C_IDLE; // [RULE_20]
                default: state <= DRS_C_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pins, all registered
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= DRS_CMD_NOP;
            link.cke     <= 1'b1;
            link.odt     <= 1'b0;
            link.reset_n <= 1'b1;
        end else begin
            link.odt     <= 1'b0;                                    // [RULE_11]
            link.reset_n <= 1'b1;
            if (state == DRS_C_IDLE && issue_ref) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= DRS_CMD_REF; // [RULE_01]
                link.cke <= 1'b1;
            end else if (state == DRS_C_ODT && wait_cnt == `DRS_CNT_W'(1)) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= DRS_CMD_REF; // [RULE_10]
                link.cke <= 1'b0;
            end else if (state == DRS_C_SELF) begin
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= DRS_CMD_NOP;
                link.cke <= (!sr_req && wait_cnt == '0);             // [RULE_12]
            end else begin
                // NOP keeps tRFC and tXS quiet
                {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= DRS_CMD_NOP; // [RULE_22]
                link.cke <= 1'b1;                                    // [RULE_20]
            end
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_self    <= 1'b0;
            write_ok   <= 1'b1;
            dll_ok     <= 1'b1;
            ck_stop_ok <= 1'b0;
        end else begin
            in_self    <= (state == DRS_C_SELF);
            write_ok   <= (post_cnt == '0) && state != DRS_C_SELF;   // [RULE_15]
            dll_ok     <= (state == DRS_C_IDLE || state == DRS_C_RFC); // [RULE_19]
            // Window closes with sr_req; CKE can rise on that same edge, so no tCKSRX margin
            ck_stop_ok <= (state == DRS_C_SELF) && sr_req
                        && wait_cnt <= `DRS_CNT_W'(`DRS_TCKSRX_CYC); // [RULE_18]
        end
    end
endmodule // drs_ctrl

/* tb/drs_link_sva.sv */
/*
 Checker on the command pins between the two ends.
 Assumes one clock, reset active high.
*/
`timescale 1ns/1ps
module drs_link_sva #(
    parameter int TREFI_CYC = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    // Side pins
    input wire logic cke,
    input wire logic odt,
    input wire logic reset_n
);
    // ------------------------------------------------------------
    // Pin decode and wait counters
    // ------------------------------------------------------------
    localparam int RFC_CYC = 40, XS_CYC = 43, XSDLL_CYC = 512;
    logic        is_ref, is_sre, is_exit, is_idle, cke_q, ref_seen;
    logic [5:0]  rfc_cnt;
    logic [5:0]  xs_cnt;
    logic [9:0]  dll_cnt;
    logic [15:0] gap_cnt;

    assign is_ref  = ({cs_n, ras_n, cas_n, we_n} == 4'h1) && cke;
    assign is_sre  = ({cs_n, ras_n, cas_n, we_n} == 4'h1) && !cke;
    assign is_exit = cke && !cke_q;
    assign is_idle = cs_n || ({ras_n, cas_n, we_n} == 3'h7);

    // Reset high: no false exit after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cke_q <= 1'b1;
        else cke_q <= cke;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rfc_cnt <= 6'h0;
        else if (is_ref) rfc_cnt <= 6'(RFC_CYC - 1);
        else if (rfc_cnt != 6'h0) rfc_cnt <= rfc_cnt - 6'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) xs_cnt <= 6'h0;
        else if (is_exit) xs_cnt <= 6'(XS_CYC - 1);
        else if (xs_cnt != 6'h0) xs_cnt <= xs_cnt - 6'h1;
    end
    // Re-entry ends the long exit window early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) dll_cnt <= 10'h0;
        else if (is_sre) dll_cnt <= 10'h0;
        else if (is_exit) dll_cnt <= 10'(XSDLL_CYC - 1);
        else if (dll_cnt != 10'h0) dll_cnt <= dll_cnt - 10'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ref_seen <= 1'b1;
        else if (is_exit) ref_seen <= 1'b0;
        else if (is_ref) ref_seen <= 1'b1;
    end
    // CKE low (self-refresh) clears the gap count to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) gap_cnt <= 16'h0;
        else if (is_ref || !cke) gap_cnt <= 16'h0;
        else gap_cnt <= gap_cnt + 16'h1;
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_entry;
        is_sre;
    endsequence
    sequence s_low_hold;
        !cke [*2];
    endsequence
    property p_entry_hold;
        s_entry |=> s_low_hold;
    endproperty

    chk_ref_rfc_idle: assert property (rfc_cnt != 6'h0 |-> is_idle && cke)
        else $error("non-idle command inside refresh cycle");
    chk_ref_gap_max: assert property (gap_cnt <= 16'(9 * TREFI_CYC))
        else $error("refresh gap above nine intervals");
    chk_sre_from_idle: assert property (s_entry |-> cke_q && !odt)
        else $error("entry while not idle or termination on");
    chk_sre_low_hold: assert property (p_entry_hold)
        else $error("clock enable rose too soon after entry");
    chk_exit_idle_cmd: assert property (is_exit |-> is_idle)
        else $error("exit without idle command");
    chk_xs_idle_cmd: assert property (xs_cnt != 6'h0 |-> is_idle)
        else $error("command other than idle inside short exit delay");
    chk_xsdll_cke_high: assert property (dll_cnt != 10'h0 |-> cke || is_sre)
        else $error("clock enable dropped inside long exit delay");
    chk_xsdll_odt_off: assert property (dll_cnt != 10'h0 |-> !odt)
        else $error("termination on inside long exit delay");
    chk_reentry_ref: assert property (s_entry |-> ref_seen)
        else $error("re-entry without a refresh after exit");
endmodule // drs_link_sva

/* tb/dram_refresh_self_refresh_tb.sv */
/*
 Bench for both link ends with a row-count model.
 Assumes drs_regs.svh on the include path.
*/
`timescale 1ns/1ps
`include "drs_regs.svh"
module dram_refresh_self_refresh_tb;
    import drs_pkg::*;
    localparam int TREFI = 64;
    localparam int LIMIT = 10000;
    logic                  clk, rst, sr_req, pull_req, dll_off_mode;
    logic                  in_self, write_ok, dll_ok, ck_stop_ok, cke_prev;
    logic                  row_busy, self_ref, dll_on, banks_idle;
    logic signed [4:0]     tally, sr_tally;
    logic [`DRS_ROW_W-1:0] row;
    logic [15:0]           lfsr;
    int                    fails, total_checks, cyc, n_ref, n_sre, entry_cyc;
    int                    due_q[$], exp_q[$];

    drs_if drs_if_i ();
    drs_ctrl #(.TREFI_CYC(TREFI)) drs_ctrl_i (.clk(clk), .rst(rst), .link(drs_if_i.ctrl),
        .sr_req(sr_req), .pull_req(pull_req), .in_self(in_self), .write_ok(write_ok),
        .dll_ok(dll_ok), .ck_stop_ok(ck_stop_ok), .tally(tally));
    drs_mem #(.TREFI_CYC(TREFI)) drs_mem_i (.clk(clk), .rst(rst), .link(drs_if_i.mem),
        .dll_off_mode(dll_off_mode), .row(row), .row_busy(row_busy), .self_ref(self_ref),
        .dll_on(dll_on), .banks_idle(banks_idle));
    drs_link_sva #(.TREFI_CYC(TREFI)) drs_link_sva_i (.clk(clk), .rst(rst),
        .cs_n(drs_if_i.cs_n), .ras_n(drs_if_i.ras_n), .cas_n(drs_if_i.cas_n),
        .we_n(drs_if_i.we_n), .cke(drs_if_i.cke), .odt(drs_if_i.odt),
        .reset_n(drs_if_i.reset_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk_bit(input string name, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %b seen %b", name, e, s);
        end
    endtask
    task automatic chk_row(input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected row expected %0h seen %0h", e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apply_reset();
        rst = 1'b1;
        n_ref = 0;
        n_sre = 0;
        due_q.delete();
        exp_q.delete();
        repeat (10) tick();
        rst = 1'b0;
    endtask
    // Bounded: a hang counts as a mismatch
    task automatic wait_high(input string name, ref logic s);
        int k;
        for (k = 0; k < 2000 && s !== 1'b1; k++) tick();
        chk_bit(name, 1'b1, s);
    endtask

    // ------------------------------------------------------------
    // Model and monitor on the wire
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cke_prev <= drs_if_i.cke;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc >= LIMIT) begin
            fails++;
            finish_test();
        end else if (!rst) begin
            chk_bit("tally_range", 1'b1, tally <= 5'sd8 && tally >= -5'sd8);
            if (due_q.size() > 0 && due_q[0] == cyc) begin
                chk_row(16'(exp_q[0]), row);
                chk_bit("row_busy", 1'b1, row_busy);
                due_q.pop_front();
                exp_q.pop_front();
            end
            if (drs_if_i.cke && {drs_if_i.cs_n, drs_if_i.ras_n, drs_if_i.cas_n,
                    drs_if_i.we_n} == DRS_CMD_REF) begin
                due_q.push_back(cyc + 20);
                exp_q.push_back(n_ref + n_sre);
                n_ref++;
            end
            if (!drs_if_i.cke && cke_prev) begin
                chk_bit("banks_idle", 1'b1, banks_idle);
                n_sre++;
                entry_cyc = cyc;
            end
            if (cyc == entry_cyc + 1) sr_tally = tally;
            if (cyc > entry_cyc + 1 && !drs_if_i.cke)
                chk_bit("tally_frozen", 1'b1, tally === sr_tally);
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sr_round(input bit quick);
        sr_req = 1'b1;
        wait_high("in_self", in_self);
        repeat (4) tick();
        chk_bit("self_ref", 1'b1, self_ref);
        chk_bit("dll_on", 1'b0, dll_on);
        chk_bit("ck_stop_ok", 1'b1, ck_stop_ok);
        lfsr = lfsr_next(lfsr);
        // Under one interval: one internal refresh
        repeat (8 + int'(lfsr[3:0])) tick();
        sr_req = 1'b0;
        wait_high("cke", drs_if_i.cke);
        repeat (5) tick();
        chk_bit("self_ref", 1'b0, self_ref);
        chk_bit("write_ok", 1'b0, write_ok);
        chk_bit("dll_ok", 1'b0, dll_ok);
        if (!quick) begin
            repeat (530) tick();
            chk_bit("write_ok", 1'b1, write_ok);
            chk_bit("dll_ok", 1'b1, dll_ok);
            chk_bit("dll_on", !dll_off_mode, dll_on);
        end
        $display("test self-refresh round done");
    endtask

    initial begin
        sr_req = 1'b0;
        pull_req = 1'b0;
        dll_off_mode = 1'b0;
        lfsr = 16'h0047;
        cyc = 0;
        fails = 0;
        total_checks = 0;
        entry_cyc = -10;
        apply_reset();
        repeat (1500) begin
            tick();
            lfsr = lfsr_next(lfsr);
            pull_req = lfsr[0];
        end
        $display("test periodic refresh done");
        pull_req = 1'b0;
        apply_reset();
        for (int i = 0; i < 3; i++) begin
            dll_off_mode = (i == 2);
            sr_round(i == 0);
        end
        finish_test();
    end
endmodule // dram_refresh_self_refresh_tb
